/* src/io_check_defines.svh */
// register map, field positions and reset values of the input bus pattern and parity checker
`ifndef IO_CHECK_DEFINES_SVH
`define IO_CHECK_DEFINES_SVH

`define ADDR_CTRL 8'h00
`define ADDR_MAP 8'h04
`define ADDR_ALARM 8'h08
`define ADDR_IRQ_STAT 8'h0C
`define ADDR_IRQ_MASK 8'h10
`define KEY_BASE_TAG 3'h1

`define CTRL_EN_BIT 0
`define CTRL_TX_BIT 1
`define CTRL_SPAR_BIT 2
`define CTRL_DPAR_BIT 3
`define CTRL_ODD_BIT 4
`define CTRL_SEL_STROBE_BIT 8
`define CTRL_SEL_SYNC_BIT 9
`define CTRL_RST 32'h0000_0100

`define ALARM_PA_BIT 0
`define ALARM_PB_BIT 1
`define ALARM_PC_BIT 2
`define ALARM_PD_BIT 3
`define ALARM_PAT_BIT 7
`define ALARM_USED 8'h8F

`define KEY0_RST 16'h7A7A
`define KEY_OTHER_RST 16'h0000

`endif

/* src/io_check_pkg.sv */
// types shared by the checker modules
package io_check_pkg;
  typedef logic [15:0] word_t;
  typedef logic [31:0] reg_t;
  typedef logic [7:0] alarm_t;
  typedef enum {ST_IDLE, ST_WAIT, ST_RUN} chk_state_t;
endpackage : io_check_pkg

/* src/link_sample_if.sv */
// synchronised link samples passed from the pin front end to the checker
`timescale 1ns/10ps
`default_nettype none
interface link_sample_if;
  logic rise;
  logic fall;
  logic [15:0] ab;
  logic [15:0] cd;
  logic strobe;
  logic sync;
  logic parity;
  logic tx_pin;
  modport source(output rise, fall, ab, cd, strobe, sync, parity, tx_pin);
  modport sink(input rise, fall, ab, cd, strobe, sync, parity, tx_pin);
endinterface : link_sample_if
`default_nettype wire

/* src/link_front.sv */
// pin synchronisers and data clock edge finder
`timescale 1ns/10ps
`default_nettype none
module link_front (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic data_clock_pin_i,
  input wire logic [15:0] bus_ab_data_i,
  input wire logic [15:0] bus_cd_data_i,
  input wire logic input_strobe_i,
  input wire logic sync_i,
  input wire logic parity_input_pin_i,
  input wire logic tx_enable_pin_i,
  link_sample_if.source link
);
  localparam int W = 37;
  logic [W-1:0] raw;
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic dclk_s3_q;

  assign raw = {tx_enable_pin_i, parity_input_pin_i, sync_i, input_strobe_i, bus_cd_data_i, bus_ab_data_i,
                data_clock_pin_i};

  // data passes the same two stages as the clock, so samples stay aligned with the found edge
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_q <= '0;
      s2_q <= '0;
      dclk_s3_q <= 1'b0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      dclk_s3_q <= s2_q[0];
    end
  end

  assign link.rise = s2_q[0] & ~dclk_s3_q;
  assign link.fall = ~s2_q[0] & dclk_s3_q;
  assign link.ab = s2_q[16:1];
  assign link.cd = s2_q[32:17];
  assign link.strobe = s2_q[33];
  assign link.sync = s2_q[34];
  assign link.parity = s2_q[35];
  assign link.tx_pin = s2_q[36];
endmodule : link_front
`default_nettype wire

/* src/input_bus_pattern_parity_checker.sv */
// input bus pattern checker and parity checker with register port and alarm interrupt
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "io_check_defines.svh"
module input_bus_pattern_parity_checker (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic [7:0] addr_i,
  input wire io_check_pkg::reg_t wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output io_check_pkg::reg_t rdata_o,
  input wire logic data_clock_pin_i,
  input wire logic [15:0] bus_ab_data_i,
  input wire logic [15:0] bus_cd_data_i,
  input wire logic input_strobe_i,
  input wire logic sync_i,
  input wire logic parity_input_pin_i,
  input wire logic tx_enable_pin_i,
  output logic dac_output_enable_o,
  output logic alarm_irq_o
);
  import io_check_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [2:0] ab_key_idx(input logic [1:0] pos);
    ab_key_idx = {pos[1], 1'b0, pos[0]};
  endfunction : ab_key_idx

  function automatic logic [2:0] cd_key_idx(input logic [1:0] pos);
    cd_key_idx = {pos[1], 1'b1, pos[0]};
  endfunction : cd_key_idx

  // xor of a group is 1 for an odd count of ones; error when it differs from the polarity
  function automatic logic par_bad(input logic ones_xor, input logic odd_sel);
    par_bad = ones_xor ^ odd_sel;
  endfunction : par_bad

  ////////////////////////////////////////////////////////////////////////////////
  link_sample_if link ();

  link_front u_front (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .data_clock_pin_i(data_clock_pin_i),
    .bus_ab_data_i(bus_ab_data_i),
    .bus_cd_data_i(bus_cd_data_i),
    .input_strobe_i(input_strobe_i),
    .sync_i(sync_i),
    .parity_input_pin_i(parity_input_pin_i),
    .tx_enable_pin_i(tx_enable_pin_i),
    .link(link)
  );

  reg_t ctrl_q;
  word_t map_q;
  word_t map_d;
  alarm_t alarm_q;
  alarm_t alarm_d;
  alarm_t stat_q;
  alarm_t stat_d;
  alarm_t mask_q;
  word_t key_q [8];
  chk_state_t state_q;
  chk_state_t state_d;
  logic [1:0] idx_q;
  logic lvl_prev_q;
  reg_t rdata_q;
  reg_t rdata_d;
  logic dac_en_q;
  logic irq_q;

  ////////////////////////////////////////////////////////////////////////////////
  // register decode
  wire hit_ctrl = addr_i == `ADDR_CTRL;
  wire hit_map = addr_i == `ADDR_MAP;
  wire hit_alarm = addr_i == `ADDR_ALARM;
  wire hit_stat = addr_i == `ADDR_IRQ_STAT;
  wire hit_mask = addr_i == `ADDR_IRQ_MASK;
  wire hit_key = (addr_i[7:5] == `KEY_BASE_TAG) && (addr_i[1:0] == 2'b00);
  wire [2:0] key_sel = addr_i[4:2];

  wire test_en = ctrl_q[`CTRL_EN_BIT];
  wire single_par = ctrl_q[`CTRL_SPAR_BIT];
  wire dual_par = ctrl_q[`CTRL_DPAR_BIT] & ~single_par;
  wire odd_sel = ctrl_q[`CTRL_ODD_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // frame start and key index
  wire edge_any = link.rise | link.fall;
  wire sel_lvl = (ctrl_q[`CTRL_SEL_STROBE_BIT] & link.strobe) | (ctrl_q[`CTRL_SEL_SYNC_BIT] & link.sync);
  // the start level is judged at data clock edges only, so a strobe that rises with the data marks that word
  wire start = test_en & edge_any & sel_lvl & ~lvl_prev_q;
  wire cmp_valid = test_en & edge_any & (start | (state_q == ST_RUN));
  wire [1:0] pos = start ? 2'd0 : idx_q;
  wire [15:0] ab_err = link.ab ^ key_q[ab_key_idx(pos)];
  wire [15:0] cd_err = link.cd ^ key_q[cd_key_idx(pos)];
  wire [15:0] bit_err = cmp_valid ? (ab_err | cd_err) : 16'h0000;

  ////////////////////////////////////////////////////////////////////////////////
  // parity
  wire x_all = ^{link.ab, link.cd, link.parity};
  wire x_ab = ^{link.ab, link.strobe};
  wire x_cd = ^{link.cd, link.parity};
  wire bad_all = single_par & par_bad(x_all, odd_sel);
  wire bad_ab = dual_par & par_bad(x_ab, odd_sel);
  wire bad_cd = dual_par & par_bad(x_cd, odd_sel);
  wire [3:0] par_ev = {link.fall & bad_cd, link.rise & bad_cd,
                       link.fall & (bad_all | bad_ab), link.rise & (bad_all | bad_ab)};
  wire [7:0] events = {|bit_err, 3'b000, par_ev};

  ////////////////////////////////////////////////////////////////////////////////
  // next values; a hardware set wins over a software clear in the same cycle
  always_comb begin
    map_d = ((wr_i & hit_map) ? wdata_i[15:0] : map_q) | bit_err;
    alarm_d = (((wr_i & hit_alarm) ? wdata_i[7:0] : alarm_q) | events) & `ALARM_USED;
    stat_d = (((rd_i & hit_stat) ? 8'h00 : stat_q) | events) & `ALARM_USED;
    case (state_q)
      // a start edge in the very cycle the test turns on must not be lost
      ST_IDLE: state_d = !test_en ? ST_IDLE : (start ? ST_RUN : ST_WAIT);
      ST_WAIT: state_d = !test_en ? ST_IDLE : (start ? ST_RUN : ST_WAIT);
      ST_RUN: state_d = test_en ? ST_RUN : ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  assign rdata_d = !rd_i ? 32'h0000_0000 :
                   hit_ctrl ? ctrl_q :
                   hit_map ? {16'h0000, map_q} :
                   hit_alarm ? {24'h00_0000, alarm_q} :
                   hit_stat ? {24'h00_0000, stat_q} :
                   hit_mask ? {24'h00_0000, mask_q} :
                   hit_key ? {16'h0000, key_q[key_sel]} : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_q <= `CTRL_RST;
      mask_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
    end else begin
      if (wr_i && hit_ctrl) begin
        ctrl_q <= wdata_i;
      end
      if (wr_i && hit_mask) begin
        mask_q <= wdata_i[7:0] & `ALARM_USED;
      end
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      key_q[0] <= `KEY0_RST;
      for (int i = 1; i < 8; i++) begin
        key_q[i] <= `KEY_OTHER_RST;
      end
    end else if (wr_i && hit_key) begin
      key_q[key_sel] <= wdata_i[15:0];
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      map_q <= 16'h0000;
      alarm_q <= 8'h00;
      stat_q <= 8'h00;
      irq_q <= 1'b0;
    end else begin
      map_q <= map_d;
      alarm_q <= alarm_d;
      stat_q <= stat_d;
      irq_q <= |(stat_d & mask_q);
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= ST_IDLE;
      idx_q <= 2'd0;
      lvl_prev_q <= 1'b0;
      dac_en_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (edge_any) begin
        lvl_prev_q <= sel_lvl;
        idx_q <= pos + 2'd1;
      end
      dac_en_q <= ~test_en & (link.tx_pin | ctrl_q[`CTRL_TX_BIT]);
    end
  end

  assign rdata_o = rdata_q;
  assign dac_output_enable_o = dac_en_q;
  assign alarm_irq_o = irq_q;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  property p_test_blocks_output;
    test_en |=> !dac_output_enable_o;
  endproperty
  a_test_blocks_output: assert property (p_test_blocks_output) else $error("output enabled during test");

  property p_key_write;
    (wr_i && hit_key) |=> key_q[$past(key_sel)] == $past(wdata_i[15:0]);
  endproperty
  a_key_write: assert property (p_key_write) else $error("key word not updated");

  property p_start_restarts;
    start |=> (idx_q == 2'd1) && (state_q == ST_RUN);
  endproperty
  a_start_restarts: assert property (p_start_restarts) else $error("index not restarted");

  property p_map_sets;
    (bit_err != 16'h0000) |=> ((map_q & $past(bit_err)) == $past(bit_err)) && alarm_q[`ALARM_PAT_BIT];
  endproperty
  a_map_sets: assert property (p_map_sets) else $error("error map or alarm missed");

  property p_map_clear;
    (wr_i && hit_map && wdata_i == 32'h0000_0000 && bit_err == 16'h0000) |=> map_q == 16'h0000;
  endproperty
  a_map_clear: assert property (p_map_clear) else $error("error map not cleared");

  property p_single_rise;
    (single_par && link.rise && (x_all != odd_sel)) |=> alarm_q[`ALARM_PA_BIT] && stat_q[`ALARM_PA_BIT];
  endproperty
  a_single_rise: assert property (p_single_rise) else $error("rising parity alarm missed");

  property p_single_fall;
    (single_par && link.fall && (x_all != odd_sel)) |=> alarm_q[`ALARM_PB_BIT] && !$past(par_ev[0]);
  endproperty
  a_single_fall: assert property (p_single_fall) else $error("falling parity alarm missed");

  property p_dual_cd;
    (dual_par && link.fall && (x_cd != odd_sel)) |=> alarm_q[`ALARM_PD_BIT] && stat_q[`ALARM_PD_BIT];
  endproperty
  a_dual_cd: assert property (p_dual_cd) else $error("cd group parity alarm missed");

  property p_key0_reset;
    $rose(arst_n_i) |-> key_q[0] == 16'h7A7A;
  endproperty
  a_key0_reset: assert property (disable iff (1'b0) p_key0_reset) else $error("key word 0 reset wrong");

  ////////////////////////////////////////////////////////////////////////////////
  // further checks, holds among them: a stray update of map, key or index would only show up as a false error much later
  property p_tx_follows;
    (!test_en && ctrl_q[`CTRL_TX_BIT]) |=> dac_output_enable_o;
  endproperty
  a_tx_follows: assert property (p_tx_follows) else $error("output not enabled by register");

  property p_key_hold;
    !(wr_i && hit_key && key_sel == 3'd0) |=> $stable(key_q[0]);
  endproperty
  a_key_hold: assert property (p_key_hold) else $error("key word 0 changed without write");

  property p_no_cmp_off;
    !test_en |-> bit_err == 16'h0000;
  endproperty
  a_no_cmp_off: assert property (p_no_cmp_off) else $error("compare while test disabled");

  property p_wait_no_cmp;
    (state_q != ST_RUN && !start) |-> bit_err == 16'h0000;
  endproperty
  a_wait_no_cmp: assert property (p_wait_no_cmp) else $error("compare before frame start");

  property p_idx_steps;
    (edge_any && !start) |=> idx_q == $past(idx_q) + 2'd1;
  endproperty
  a_idx_steps: assert property (p_idx_steps) else $error("key index did not step");

  property p_idx_hold;
    !edge_any |=> $stable(idx_q);
  endproperty
  a_idx_hold: assert property (p_idx_hold) else $error("key index moved without edge");

  property p_map_write;
    (wr_i && hit_map) |=> map_q == ($past(wdata_i[15:0]) | $past(bit_err));
  endproperty
  a_map_write: assert property (p_map_write) else $error("error map write wrong");

  property p_map_holds;
    (!(wr_i && hit_map) && bit_err == 16'h0000) |=> $stable(map_q);
  endproperty
  a_map_holds: assert property (p_map_holds) else $error("error map changed without cause");

  property p_alarm_clear;
    (wr_i && hit_alarm && wdata_i == 32'h0000_0000 && events == 8'h00) |=> alarm_q == 8'h00;
  endproperty
  a_alarm_clear: assert property (p_alarm_clear) else $error("alarm not cleared");

  property p_dual_ab_rise;
    (dual_par && link.rise && (x_ab != odd_sel)) |=> alarm_q[`ALARM_PA_BIT] && stat_q[`ALARM_PA_BIT];
  endproperty
  a_dual_ab_rise: assert property (p_dual_ab_rise) else $error("ab group parity alarm missed");

  property p_parity_off;
    (!single_par && !dual_par) |-> par_ev == 4'h0;
  endproperty
  a_parity_off: assert property (p_parity_off) else $error("parity event with parity off");
endmodule : input_bus_pattern_parity_checker
`default_nettype wire

/* tb/pattern_source.sv */
// data source model that drives the double data rate buses, strobe, sync and parity pins
`timescale 1ns/10ps
`default_nettype none
module pattern_source (
  input wire logic run_i,
  input wire logic [15:0] key_i [8],
  input wire logic [15:0] err_ab_i,
  input wire logic [15:0] err_cd_i,
  input wire logic odd_i,
  input wire logic dual_i,
  input wire logic perr_rise_i,
  input wire logic perr_fall_i,
  output logic data_clock_o,
  output logic [15:0] ab_o,
  output logic [15:0] cd_o,
  output logic strobe_o,
  output logic sync_o,
  output logic parity_o
);
  ////////////////////////////////////////////////////////////////////////////////
  // data changes mid half period so it is settled across the receiver's two flops
  task automatic half(input logic [1:0] pos, input logic st);
    ab_o = key_i[{pos[1], 1'b0, pos[0]}] ^ ((pos == 2'd0) ? err_ab_i : 16'h0000);
    cd_o = key_i[{pos[1], 1'b1, pos[0]}] ^ ((pos == 2'd1) ? err_cd_i : 16'h0000);
    strobe_o = dual_i ? (^ab_o ^ odd_i) : st;
    sync_o = dual_i & st;
    parity_o = (dual_i ? ^cd_o : ^{ab_o, cd_o}) ^ odd_i
               ^ (perr_rise_i & ~pos[0]) ^ (perr_fall_i & pos[0]);
    #20;
    data_clock_o = ~pos[0];
    #20;
  endtask : half
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    data_clock_o = 1'b0;
    ab_o = 16'h0000;
    cd_o = 16'h0000;
    strobe_o = 1'b0;
    sync_o = 1'b0;
    parity_o = 1'b0;
    forever begin
      wait (run_i);
      // one edge pair with the start pin low, so the next edge sees it rise
      half(2'd0, 1'b0);
      half(2'd1, 1'b0);
      while (run_i) begin
        for (int i = 0; i < 4; i++) half(i[1:0], 1'b1);
      end
      // released lines do not keep their last level; the clock stands still low
      ab_o = ~ab_o;
      cd_o = ~cd_o;
      parity_o = ~parity_o;
      strobe_o = 1'b0;
      sync_o = 1'b0;
    end
  end
endmodule : pattern_source
`default_nettype wire

/* tb/tb.sv */
// self-checking testbench of the input bus pattern and parity checker
`timescale 1ns/10ps
`default_nettype none
`include "io_check_defines.svh"
module tb;
  import io_check_pkg::*;
  typedef struct {logic [7:0] a; reg_t v;} row_t;
  logic clock_i, arst_n_i, wr_i, rd_i, tx_pin, oe, irq, dclk, strobe, sync, par;
  logic run, odd, dual, perr, perr_fall;
  logic [7:0] addr;
  reg_t wdata, rdata_o, got;
  logic [15:0] ab, cd, err_ab, err_cd;
  logic [15:0] key [8];
  int fail_count = 0;
  int n_compared = 0;
  row_t rows [6] = '{'{`ADDR_CTRL, 32'h0000_0100}, '{`ADDR_MAP, 32'h0000_0000}, '{`ADDR_ALARM, 32'h0000_0000},
    '{8'h20, 32'h0000_7A7A}, '{8'h3C, 32'h0000_0000}, '{8'h40, 32'h0000_0000}};
  ////////////////////////////////////////////////////////////////////////////////
  input_bus_pattern_parity_checker dut (.clock_i(clock_i), .arst_n_i(arst_n_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .data_clock_pin_i(dclk), .bus_ab_data_i(ab), .bus_cd_data_i(cd),
    .input_strobe_i(strobe), .sync_i(sync), .parity_input_pin_i(par), .tx_enable_pin_i(tx_pin),
    .dac_output_enable_o(oe), .alarm_irq_o(irq));
  pattern_source src (.run_i(run), .key_i(key), .err_ab_i(err_ab), .err_cd_i(err_cd), .odd_i(odd), .dual_i(dual),
    .perr_rise_i(perr), .perr_fall_i(perr_fall), .data_clock_o(dclk), .ab_o(ab), .cd_o(cd),
    .strobe_o(strobe), .sync_o(sync),
    .parity_o(par));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input reg_t d);
    @(posedge clock_i);
    addr <= a;
    wdata <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic cmp(input reg_t g, input reg_t e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: read %h, wanted %h", $time, g, e);
    end
  endtask : cmp
  task automatic cmp_bit(input logic g, input logic e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: output %b, wanted %b", $time, g, e);
    end
  endtask : cmp_bit
  // read data stands only in the cycle after the strobe, so it is taken there
  task automatic chk(input logic [7:0] a, input reg_t e);
    @(posedge clock_i);
    addr <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1;
    got = rdata_o;
    cmp(got, e);
  endtask : chk
  // sequences of four data edges last 16 system clocks; the tail lets the last one land
  task automatic run_frames(input int n);
    @(posedge clock_i);
    run <= 1'b1;
    repeat (n * 16) @(posedge clock_i);
    run <= 1'b0;
    repeat (40) @(posedge clock_i);
  endtask : run_frames
  task automatic report_and_stop;
    if (fail_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  initial begin
    {arst_n_i, wr_i, rd_i, run, odd, dual, perr, perr_fall} = 8'h00;
    {addr, wdata, err_ab, err_cd} = '0;
    tx_pin = 1'b1;
    for (int i = 0; i < 8; i++) key[i] = (i == 0) ? 16'h7A7A : 16'(16'h1357 * i);
    repeat (20) @(posedge clock_i);
    arst_n_i <= 1'b1;
    for (int i = 0; i < 6; i++) chk(rows[i].a, rows[i].v);
    wr(`ADDR_IRQ_MASK, 32'h0000_0080);
    repeat (4) @(posedge clock_i);
    cmp_bit(oe, 1'b1);
    tx_pin <= 1'b0;
    repeat (4) @(posedge clock_i);
    cmp_bit(oe, 1'b0);
    wr(`ADDR_CTRL, 32'h0000_0102);
    repeat (4) @(posedge clock_i);
    cmp_bit(oe, 1'b1);
    wr(`ADDR_CTRL, 32'h0000_0103);
    repeat (4) @(posedge clock_i);
    cmp_bit(oe, 1'b0);
    tx_pin <= 1'b1;
    wr(`ADDR_CTRL, 32'h0000_0101);
    repeat (4) @(posedge clock_i);
    cmp_bit(oe, 1'b0);
    for (int i = 1; i < 8; i++) wr(8'h20 + 8'(4 * i), {16'h0000, key[i]});
    run_frames(110);
    wr(`ADDR_MAP, 32'h0000_0000);
    wr(`ADDR_ALARM, 32'h0000_0000);
    run_frames(10);
    chk(`ADDR_MAP, 32'h0000_0000);
    chk(`ADDR_ALARM, 32'h0000_0000);
    cmp_bit(irq, 1'b0);
    err_ab = 16'h0001;
    err_cd = 16'h0100;
    run_frames(4);
    cmp_bit(irq, 1'b1);
    chk(`ADDR_MAP, 32'h0000_0101);
    chk(`ADDR_ALARM, 32'h0000_0080);
    chk(`ADDR_IRQ_STAT, 32'h0000_0080);
    repeat (4) @(posedge clock_i);
    cmp_bit(irq, 1'b0);
    wr(`ADDR_MAP, 32'h0000_0000);
    wr(`ADDR_ALARM, 32'h0000_0000);
    chk(`ADDR_MAP, 32'h0000_0000);
    chk(`ADDR_ALARM, 32'h0000_0000);
    // a rewritten key word is used from then on while the source still sends the old one
    err_ab = 16'h0000;
    err_cd = 16'h0000;
    wr(8'h24, {16'h0000, key[1] ^ 16'h8000});
    run_frames(4);
    chk(`ADDR_MAP, 32'h0000_8000);
    wr(8'h24, {16'h0000, key[1]});
    wr(`ADDR_MAP, 32'h0000_0000);
    wr(`ADDR_ALARM, 32'h0000_0000);
    odd = 1'b1;
    perr = 1'b1;
    wr(`ADDR_CTRL, 32'h0000_0114);
    run_frames(4);
    chk(`ADDR_ALARM, 32'h0000_0001);
    wr(`ADDR_ALARM, 32'h0000_0000);
    // falling-edge words only carry the bad parity now
    perr = 1'b0;
    perr_fall = 1'b1;
    run_frames(4);
    chk(`ADDR_ALARM, 32'h0000_0002);
    wr(`ADDR_ALARM, 32'h0000_0000);
    perr = 1'b1;
    perr_fall = 1'b0;
    dual = 1'b1;
    wr(`ADDR_CTRL, 32'h0000_0219);
    run_frames(8);
    chk(`ADDR_ALARM, 32'h0000_0004);
    chk(`ADDR_MAP, 32'h0000_0000);
    cmp_bit(oe, 1'b0);
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
